// *** adcrat_top.sv ***
// Purpose: Converter result registers, auto trigger and Wishbone slave
// Assumes: trig_flags_i come from on-chip logic on clk_i
// Notes:   Result bytes lock from a low-byte read until a high-byte read
`timescale 1ns/100ps
`include "adcrat_regs.svh"

// Contract
// - A finished conversion loads the 10-bit result into the low/high byte pair.
// - Differential channels give a two's complement result.
// - Low-byte read blocks result updates until the high byte is read.
// - Right adjust: bits 9:8 in high 1:0, 7:0 in low, rest zero.
// - Left adjust: bits 9:2 in high, 1:0 in low 7:6, rest zero.
// - Trigger source field at 7:5 has no effect unless auto trigger is on.
// - Auto trigger starts a conversion on each rising edge of selected flag; the code ignores an edge that comes while a conversion is busy.
// - Switching from a clear source to a set source is a rising edge.
// - Selecting free running source zero never makes a trigger event.
// - Source codes: free, comparator, ext irq 0, T0 cmp, T0 ovf, T1 cmpB, ovf, cap.
// - High speed bit 4 selects a faster conversion rate.
// - Writing one to auto trigger enable turns on auto triggering.
// - Done flag sets when a conversion finishes; it is the free running trigger.
module adcrat_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [7:1]  trig_flags_i,
   input  wire logic [9:0]  sample_i,
   output logic             irq_o,
   output logic             high_speed_o,
   output logic      [4:0]  channel_o
);

   // -----------------------------------------------------------------
   // State and helpers
   // -----------------------------------------------------------------
   adcrat_pkg::adcrat_top_s q;
   adcrat_pkg::adcrat_top_s d;

   logic       conv_busy;
   logic       conv_done;
   logic [9:0] conv_result;
   logic       conv_start;
   logic       req;
   logic       wr;
   logic       rd;
   logic       sw_start;
   logic       trig_now;
   logic       trig_edge;
   logic       free_run;
   logic [2:0] src;
   logic       diff_sel;

   // Byte presentation of the stored result
   function automatic logic [7:0] present(input logic [9:0] r, input logic ladj,
                                          input logic hi);
      logic [7:0] b;
      if (ladj) begin
         b = hi ? r[9:2] : {r[1:0], 6'h00};
      end else begin
         b = hi ? {6'h00, r[9:8]} : r[7:0];
      end
      return b;
   endfunction

   // Level of the selected trigger flag; free running gives none
   function automatic logic trig_level(input logic [2:0] s, input logic [7:1] f);
      logic l;
      unique case (adcrat_pkg::adcrat_src_e'(s))
         adcrat_pkg::ADCRAT_SRC_FREE:  l = 1'b0;
         adcrat_pkg::ADCRAT_SRC_ACMP:  l = f[1];
         adcrat_pkg::ADCRAT_SRC_EXT0:  l = f[2];
         adcrat_pkg::ADCRAT_SRC_T0CM:  l = f[3];
         adcrat_pkg::ADCRAT_SRC_T0OV:  l = f[4];
         adcrat_pkg::ADCRAT_SRC_T1CMB: l = f[5];
         adcrat_pkg::ADCRAT_SRC_T1OV:  l = f[6];
         adcrat_pkg::ADCRAT_SRC_T1CAP: l = f[7];
      endcase
      return l;
   endfunction

   // -----------------------------------------------------------------
   // Conversion sequencer
   // -----------------------------------------------------------------
   adcrat_conv u_conv (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .enable_i     (q.ctrl[`ADCRAT_CTRL_EN_BIT]),
      .start_i      (conv_start),
      .prescale_i   (q.ctrl[`ADCRAT_CTRL_PS_MSB:0]),
      .high_speed_i (q.sfio[`ADCRAT_SFIO_HS_BIT]),
      .diff_i       (diff_sel),
      .sample_i     (sample_i),
      .busy_o       (conv_busy),
      .done_o       (conv_done),
      .result_o     (conv_result)
   );

   // -----------------------------------------------------------------
   // Bus decode and trigger
   // -----------------------------------------------------------------
   always_comb begin
      req      = wb_cyc_i && wb_stb_i && !q.ack;
      wr       = req && wb_we_i && wb_sel_i[0];
      rd       = req && !wb_we_i;
      src      = q.sfio[`ADCRAT_SFIO_TS_MSB:`ADCRAT_SFIO_TS_LSB];
      diff_sel = (q.chsel[`ADCRAT_CH_MUX_MSB:0] >= `ADCRAT_DIFF_FIRST)
              && (q.chsel[`ADCRAT_CH_MUX_MSB:0] <= `ADCRAT_DIFF_LAST);
      // Software start; first conversion of free running comes from here
      sw_start = wr && (wb_adr_i == `ADCRAT_OFF_CTRL)
              && wb_dat_i[`ADCRAT_CTRL_SC_BIT];
      trig_now = trig_level(src, trig_flags_i);
      // Edge from previous selected level, so a switch counts too
      trig_edge = q.ctrl[`ADCRAT_CTRL_AT_BIT] && trig_now && !q.trig_prev;
      free_run  = q.ctrl[`ADCRAT_CTRL_AT_BIT]
               && (src == adcrat_pkg::ADCRAT_SRC_FREE) && conv_done;
      conv_start = q.ctrl[`ADCRAT_CTRL_EN_BIT] && !conv_busy
                && (sw_start || trig_edge || free_run);
   end

   // -----------------------------------------------------------------
   // Register file and result
   // -----------------------------------------------------------------
   always_comb begin
      d           = q;
      d.ack       = req;
      d.trig_prev = trig_now;

      if (wr) begin
         unique case (wb_adr_i)
            `ADCRAT_OFF_SFIO:  d.sfio  = wb_dat_i[7:0];
            `ADCRAT_OFF_CHSEL: d.chsel = wb_dat_i[7:0];
            `ADCRAT_OFF_CTRL: begin
               d.ctrl[7:5] = wb_dat_i[7:5];
               d.ctrl[3:0] = wb_dat_i[3:0];
               d.ctrl[`ADCRAT_CTRL_SC_BIT] = 1'b0;
               if (wb_dat_i[`ADCRAT_CTRL_DF_BIT]) begin
                  d.ctrl[`ADCRAT_CTRL_DF_BIT] = 1'b0;
               end
            end
            `ADCRAT_OFF_IMASK: d.imask = wb_dat_i[1:0];
            default: d.imask = q.imask;
         endcase
      end

      d.dat = 32'h0000_0000;
      if (rd) begin
         unique case (wb_adr_i)
            `ADCRAT_OFF_RES_LOW: begin
               d.dat[7:0] = present(q.res, q.chsel[`ADCRAT_CH_LADJ_BIT], 1'b0);
               d.locked   = 1'b1;
            end
            `ADCRAT_OFF_RES_HIGH: begin
               d.dat[7:0] = present(q.res, q.chsel[`ADCRAT_CH_LADJ_BIT], 1'b1);
               d.locked   = 1'b0;
            end
            `ADCRAT_OFF_SFIO:  d.dat[7:0] = q.sfio;
            `ADCRAT_OFF_CHSEL: d.dat[7:0] = q.chsel;
            `ADCRAT_OFF_CTRL: begin
               d.dat[7:0] = q.ctrl;
               d.dat[`ADCRAT_CTRL_SC_BIT] = conv_busy;
            end
            `ADCRAT_OFF_ISTAT: begin
               d.dat[1:0] = q.istat;
               d.istat    = `ADCRAT_RST_IRQ;
            end
            `ADCRAT_OFF_IMASK: d.dat[1:0] = q.imask;
            default: d.dat = 32'h0000_0000;
         endcase
      end

      // Hardware sets after software clears, so a set wins
      if (conv_done) begin
         if (!q.locked) begin
            d.res = conv_result;
         end
         d.ctrl[`ADCRAT_CTRL_DF_BIT]  = 1'b1;
         d.istat[`ADCRAT_IRQ_DONE_BIT] = 1'b1;
      end
      if (conv_start && trig_edge) begin
         d.istat[`ADCRAT_IRQ_TRIG_BIT] = 1'b1;
      end
      if (!d.ctrl[`ADCRAT_CTRL_EN_BIT]) begin
         d.ctrl[`ADCRAT_CTRL_SC_BIT] = 1'b0;
      end
      d.irq = |(d.istat & d.imask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign wb_dat_o     = q.dat;
   assign wb_ack_o     = q.ack;
   assign irq_o        = q.irq;
   assign high_speed_o = q.sfio[`ADCRAT_SFIO_HS_BIT];
   assign channel_o    = q.chsel[`ADCRAT_CH_MUX_MSB:0];

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> (wb_ack_o ##1 !wb_ack_o))
      else $error("ack not a single cycle after request");

   a_result_load: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_done && !q.locked) |=> (q.res == $past(conv_result)))
      else $error("result not loaded on completion");

   a_result_lock: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.locked && !(rd && wb_adr_i == `ADCRAT_OFF_RES_HIGH))
      |=> (q.locked && $stable(q.res)))
      else $error("locked result changed");

   a_right_adjust: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && wb_adr_i == `ADCRAT_OFF_RES_HIGH && !q.chsel[`ADCRAT_CH_LADJ_BIT])
      |=> (wb_dat_o[7:2] == 6'h00 && wb_dat_o[1:0] == $past(q.res[9:8])))
      else $error("right adjusted high byte wrong");

   a_left_adjust: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && wb_adr_i == `ADCRAT_OFF_RES_LOW && q.chsel[`ADCRAT_CH_LADJ_BIT])
      |=> (wb_dat_o[5:0] == 6'h00 && wb_dat_o[7:6] == $past(q.res[1:0])))
      else $error("left adjusted low byte wrong");

   a_trig_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (!q.ctrl[`ADCRAT_CTRL_AT_BIT] && !sw_start && !conv_busy) |=> !conv_busy)
      else $error("start without auto trigger or software");

   a_trig_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.ctrl[`ADCRAT_CTRL_AT_BIT] && q.ctrl[`ADCRAT_CTRL_EN_BIT] && !conv_busy
       && trig_now && !q.trig_prev) |=> conv_busy)
      else $error("trigger edge did not start conversion");

   a_free_no_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      (src == adcrat_pkg::ADCRAT_SRC_FREE && !sw_start && !conv_done && !conv_busy)
      |=> !conv_busy)
      else $error("free running source made a trigger edge");

   a_done_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      conv_done |=> (q.ctrl[`ADCRAT_CTRL_DF_BIT] && q.istat[`ADCRAT_IRQ_DONE_BIT]))
      else $error("done flags not set on completion");

   a_free_next: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_done && q.ctrl[`ADCRAT_CTRL_AT_BIT] && q.ctrl[`ADCRAT_CTRL_EN_BIT]
       && src == adcrat_pkg::ADCRAT_SRC_FREE) |=> conv_busy)
      else $error("free running did not restart");

   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 (irq_o == |(q.istat & q.imask)))
      else $error("interrupt level disagrees with status and mask");

   // -----------------------------------------------------------------
   // Bus and register checks
   // -----------------------------------------------------------------
   a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
      else $error("read data not zero outside an ack");

   a_dat_upper: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");

   a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      (!(wb_cyc_i && wb_stb_i) && !wb_ack_o) |=> !wb_ack_o)
      else $error("ack without a request");

   a_busy_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && wb_adr_i == `ADCRAT_OFF_CTRL)
      |=> (wb_dat_o[`ADCRAT_CTRL_SC_BIT] == $past(conv_busy)))
      else $error("start bit does not read as busy");

   a_chan_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == `ADCRAT_OFF_CHSEL)
      |=> (channel_o == $past(wb_dat_i[`ADCRAT_CH_MUX_MSB:0])))
      else $error("channel output not written");

   a_hs_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == `ADCRAT_OFF_SFIO)
      |=> (high_speed_o == $past(wb_dat_i[`ADCRAT_SFIO_HS_BIT])))
      else $error("high speed output not written");

   a_auto_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == `ADCRAT_OFF_CTRL)
      |=> (q.ctrl[`ADCRAT_CTRL_AT_BIT] == $past(wb_dat_i[`ADCRAT_CTRL_AT_BIT])))
      else $error("auto trigger enable not written");

   a_sw_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (sw_start && q.ctrl[`ADCRAT_CTRL_EN_BIT] && !conv_busy) |=> conv_busy)
      else $error("software start ignored");

   a_off_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.ctrl[`ADCRAT_CTRL_EN_BIT] |=> !conv_busy)
      else $error("converter busy while disabled");

   a_lock_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && wb_adr_i == `ADCRAT_OFF_RES_LOW) |=> q.locked)
      else $error("low byte read did not lock");

   a_lock_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && wb_adr_i == `ADCRAT_OFF_RES_HIGH) |=> !q.locked)
      else $error("high byte read did not unlock");

   a_right_low: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && wb_adr_i == `ADCRAT_OFF_RES_LOW && !q.chsel[`ADCRAT_CH_LADJ_BIT])
      |=> (wb_dat_o[7:0] == $past(q.res[7:0])))
      else $error("right adjusted low byte wrong");

   a_left_high: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && wb_adr_i == `ADCRAT_OFF_RES_HIGH && q.chsel[`ADCRAT_CH_LADJ_BIT])
      |=> (wb_dat_o[7:0] == $past(q.res[9:2])))
      else $error("left adjusted high byte wrong");

   a_src_decode: assert property (@(posedge clk_i) disable iff (rst_i)
      (src != adcrat_pkg::ADCRAT_SRC_FREE) |-> (trig_now == trig_flags_i[src]))
      else $error("trigger source decode wrong");

   a_trig_status: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_start && trig_edge) |=> q.istat[`ADCRAT_IRQ_TRIG_BIT])
      else $error("trigger status not set");

   a_done_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == `ADCRAT_OFF_CTRL && wb_dat_i[`ADCRAT_CTRL_DF_BIT] && !conv_done)
      |=> !q.ctrl[`ADCRAT_CTRL_DF_BIT])
      else $error("done flag not cleared by a one");

   a_stat_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && wb_adr_i == `ADCRAT_OFF_ISTAT && !conv_done && !(conv_start && trig_edge))
      |=> (q.istat == `ADCRAT_RST_IRQ))
      else $error("status not cleared by a read");

endmodule

// *** adcrat_regs.svh ***
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: Word-aligned registers on a 32-bit classic Wishbone slave
// Notes:   Registers carry 8 bits in the low byte, ISTAT and IMASK only 2; upper bits read zero
`ifndef ADCRAT_REGS_SVH
`define ADCRAT_REGS_SVH

// -----------------------------------------------------------------
// Offsets
// -----------------------------------------------------------------
`define ADCRAT_OFF_RES_LOW   8'h00
`define ADCRAT_OFF_RES_HIGH  8'h04
`define ADCRAT_OFF_SFIO      8'h08
`define ADCRAT_OFF_CHSEL     8'h0C
`define ADCRAT_OFF_CTRL      8'h10
`define ADCRAT_OFF_ISTAT     8'h14
`define ADCRAT_OFF_IMASK     8'h18

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define ADCRAT_SFIO_TS_MSB   7
`define ADCRAT_SFIO_TS_LSB   5
`define ADCRAT_SFIO_HS_BIT   4
`define ADCRAT_CH_LADJ_BIT   5
`define ADCRAT_CH_MUX_MSB    4
`define ADCRAT_CTRL_EN_BIT   7
`define ADCRAT_CTRL_SC_BIT   6
`define ADCRAT_CTRL_AT_BIT   5
`define ADCRAT_CTRL_DF_BIT   4
`define ADCRAT_CTRL_PS_MSB   2
`define ADCRAT_IRQ_DONE_BIT  0
`define ADCRAT_IRQ_TRIG_BIT  1

// -----------------------------------------------------------------
// Reset values and counts
// -----------------------------------------------------------------
`define ADCRAT_RST_BYTE      8'h00
`define ADCRAT_RST_RESULT    10'h000
`define ADCRAT_RST_IRQ       2'h0
`define ADCRAT_CONV_CLKS     5'h0D
`define ADCRAT_FIRST_CLKS    5'h19
`define ADCRAT_DIFF_FIRST    5'h08
`define ADCRAT_DIFF_LAST     5'h1D

`endif

// *** adcrat_pkg.sv ***
// Purpose: Types shared by the converter control block
// Assumes: Constants live in adcrat_regs.svh
// Notes:   State of adcrat_top and of adcrat_conv is one packed struct each
package adcrat_pkg;

   typedef enum logic [1:0] {
      ADCRAT_IDLE = 2'b00,
      ADCRAT_RUN  = 2'b01,
      ADCRAT_DONE = 2'b11
   } adcrat_state_e;

   typedef enum logic [2:0] {
      ADCRAT_SRC_FREE  = 3'h0,
      ADCRAT_SRC_ACMP  = 3'h1,
      ADCRAT_SRC_EXT0  = 3'h2,
      ADCRAT_SRC_T0CM  = 3'h3,
      ADCRAT_SRC_T0OV  = 3'h4,
      ADCRAT_SRC_T1CMB = 3'h5,
      ADCRAT_SRC_T1OV  = 3'h6,
      ADCRAT_SRC_T1CAP = 3'h7
   } adcrat_src_e;

   typedef struct packed {
      adcrat_state_e st;
      logic [7:0]    div_cnt;
      logic [4:0]    clk_cnt;
      logic          warm;
      logic [9:0]    sync1;
      logic [9:0]    sync2;
      logic [9:0]    res;
      logic          done;
   } adcrat_conv_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
      logic        irq;
      logic [9:0]  res;
      logic        locked;
      logic [7:0]  chsel;
      logic [7:0]  sfio;
      logic [7:0]  ctrl;
      logic [1:0]  istat;
      logic [1:0]  imask;
      logic        trig_prev;
   } adcrat_top_s;

endpackage

// *** adcrat_conv.sv ***
// Purpose: Conversion sequencer: paces one conversion, captures the sample
// Assumes: sample_i comes from the analog front end in offset binary
// Notes:   First conversion after enable takes the longer count
`timescale 1ns/100ps
`include "adcrat_regs.svh"

module adcrat_conv (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       enable_i,
   input  wire logic       start_i,
   input  wire logic [2:0] prescale_i,
   input  wire logic       high_speed_i,
   input  wire logic       diff_i,
   input  wire logic [9:0] sample_i,
   output logic            busy_o,
   output logic            done_o,
   output logic [9:0]      result_o
);

   adcrat_pkg::adcrat_conv_s q;
   adcrat_pkg::adcrat_conv_s d;

   // Terminal count of the converter clock divider
   function automatic logic [7:0] div_term(input logic [2:0] ps, input logic hs);
      logic [7:0] f;
      f = (ps == 3'h0) ? 8'h02 : (8'h01 << ps);
      if (hs) begin
         f = (f > 8'h02) ? (f >> 1) : 8'h01;
      end
      return f - 8'h01;
   endfunction

   always_comb begin
      d       = q;
      d.sync1 = sample_i;
      d.sync2 = q.sync1;
      d.done  = 1'b0;
      if (!enable_i) begin
         d.st   = adcrat_pkg::ADCRAT_IDLE;
         d.warm = 1'b0;
      end else begin
         unique case (q.st)
            adcrat_pkg::ADCRAT_IDLE: begin
               if (start_i) begin
                  d.st      = adcrat_pkg::ADCRAT_RUN;
                  d.div_cnt = 8'h00;
                  d.clk_cnt = (q.warm ? `ADCRAT_CONV_CLKS : `ADCRAT_FIRST_CLKS) - 5'h01;
               end
            end
            adcrat_pkg::ADCRAT_RUN: begin
               if (q.div_cnt == div_term(prescale_i, high_speed_i)) begin
                  d.div_cnt = 8'h00;
                  if (q.clk_cnt == 5'h00) begin
                     d.st = adcrat_pkg::ADCRAT_DONE;
                  end else begin
                     d.clk_cnt = q.clk_cnt - 5'h01;
                  end
               end else begin
                  d.div_cnt = q.div_cnt + 8'h01;
               end
            end
            adcrat_pkg::ADCRAT_DONE: begin
               // Differential result as two's complement
               d.res  = diff_i ? {~q.sync2[9], q.sync2[8:0]} : q.sync2;
               d.done = 1'b1;
               d.warm = 1'b1;
               d.st   = adcrat_pkg::ADCRAT_IDLE;
            end
            default: d.st = adcrat_pkg::ADCRAT_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign busy_o   = (q.st != adcrat_pkg::ADCRAT_IDLE);
   assign done_o   = q.done;
   assign result_o = q.res;

   a_diff_encode: assert property (@(posedge clk_i) disable iff (rst_i)
      (enable_i && q.st == adcrat_pkg::ADCRAT_DONE && diff_i)
      |=> (q.res[9] == !$past(q.sync2[9])))
      else $error("differential result not two's complement");

endmodule

// *** adcrat_peer.sv ***
// Purpose: Far side model: peripheral trigger flags and analog front end
// Assumes: Flags are levels on clk_i, raised and dropped by peripherals
// Notes:   Sample is held steady between requests so a capture is clean
`timescale 1ns/100ps

module adcrat_peer (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [7:1] flag_req_i,
   input  wire logic [9:0] level_req_i,
   output logic      [7:1] trig_flags_o,
   output logic      [9:0] sample_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_flags_o <= 7'h00;
         sample_o     <= 10'h000;
      end else begin
         trig_flags_o <= flag_req_i;
         sample_o     <= level_req_i;
      end
   end
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench for the converter result and trigger block
// Assumes: Classic Wishbone single cycles with an idle cycle between them
// Notes:   Reference model keeps expected results in a queue
`timescale 1ns/100ps
`include "adcrat_regs.svh"

module tb;
   logic        clk_i, rst_i, cyc, stb, we, ack, irq, hs;
   logic [7:0]  adr, q;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [4:0]  chan;
   logic [7:1]  flag_req, flags;
   logic [9:0]  level_req, sample;
   int          n_errors, checked, seed, last_res, old_res, mask_m, c_norm, c_fast, s;
   int          exp_q[$];
   bit          ladj;

   adcrat_peer u_adcrat_peer (.clk_i(clk_i), .rst_i(rst_i), .flag_req_i(flag_req),
      .level_req_i(level_req), .trig_flags_o(flags), .sample_o(sample));
   adcrat_top u_adcrat_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .trig_flags_i(flags), .sample_i(sample), .irq_o(irq),
      .high_speed_o(hs), .channel_o(chan));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // Bus cycles and comparisons
   // ---------------------------------------------------------------
   task automatic give_verdict;
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'hF;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         n_errors++;
         $display("wrong value at %0t: no bus acknowledge", $time);
         give_verdict();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00);
      chk(q, exp);
   endtask

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   function automatic logic [7:0] byte_of(input int r, input bit left, input bit hi);
      logic [9:0] v;
      v = r[9:0];
      if (left) return hi ? v[9:2] : {v[1:0], 6'h00};
      return hi ? {6'h00, v[9:8]} : v[7:0];
   endfunction

   task automatic check_res;
      rd(`ADCRAT_OFF_RES_LOW, byte_of(last_res, ladj, 1'b0));
      rd(`ADCRAT_OFF_RES_HIGH, byte_of(last_res, ladj, 1'b1));
   endtask

   task automatic new_sample(input int xor_v);
      s = $random(seed) & 32'h3FF;
      level_req <= s[9:0];
      exp_q.push_back(s ^ xor_v);
   endtask

   task automatic finish_conv(input logic [1:0] ist, input logic [7:0] clr, output int n);
      n = 0;
      do begin
         wb(1'b0, `ADCRAT_OFF_CTRL, 8'h00);
         n++;
      end while (q[4] !== 1'b1 && n < 3000);
      if (q[4] !== 1'b1) begin
         n_errors++;
         $display("wrong value at %0t: conversion never finished", $time);
         give_verdict();
      end
      @(posedge clk_i);
      chk({7'h00, irq}, {7'h00, (mask_m & ist) != 0});
      rd(`ADCRAT_OFF_ISTAT, {6'h00, ist});
      repeat (2) @(posedge clk_i);
      chk({7'h00, irq}, 8'h00);
      last_res = exp_q.pop_front();
      if (clr != 8'h00) wb(1'b1, `ADCRAT_OFF_CTRL, clr);
   endtask

   task automatic no_conv;
      repeat (200) @(posedge clk_i);
      rd(`ADCRAT_OFF_ISTAT, 8'h00);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 88293;
      n_errors = 0;
      checked = 0;
      mask_m = 0;
      ladj = 1'b0;
      last_res = 0;
      rst_i = 1'b1;
      {cyc, stb, we, adr, sel, wdat, flag_req, level_req} = '0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      check_res();
      rd(8'h1C, 8'h00);
      chk({6'h00, hs, irq}, 8'h00);
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'h80);
      new_sample(0);
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'hC0);
      finish_conv(2'b01, 8'h90, c_norm);
      wb(1'b1, `ADCRAT_OFF_RES_LOW, 8'hFF);
      check_res();
      mask_m = 3;
      wb(1'b1, `ADCRAT_OFF_IMASK, 8'h03);
      rd(`ADCRAT_OFF_RES_LOW, byte_of(last_res, 1'b0, 1'b0));
      old_res = last_res;
      new_sample(0);
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'hC0);
      finish_conv(2'b01, 8'h90, c_norm);
      last_res = old_res;
      check_res();
      wb(1'b1, `ADCRAT_OFF_CHSEL, 8'h08);
      chk({3'h0, chan}, 8'h08);
      new_sample(32'h200);
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'hC0);
      finish_conv(2'b01, 8'h90, c_norm);
      check_res();
      wb(1'b1, `ADCRAT_OFF_CHSEL, 8'h28);
      ladj = 1'b1;
      check_res();
      rd(`ADCRAT_OFF_RES_HIGH, byte_of(last_res, 1'b1, 1'b1));
      wb(1'b1, `ADCRAT_OFF_CHSEL, 8'h00);
      ladj = 1'b0;
      new_sample(0);
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'hC7);
      finish_conv(2'b01, 8'h97, c_norm);
      wb(1'b1, `ADCRAT_OFF_SFIO, 8'h10);
      chk({7'h00, hs}, 8'h01);
      rd(`ADCRAT_OFF_SFIO, 8'h10);
      new_sample(0);
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'hC7);
      finish_conv(2'b01, 8'h90, c_fast);
      checked++;
      if (c_fast >= c_norm) begin
         n_errors++;
         $display("wrong value at %0t: high speed not faster", $time);
      end
      check_res();
      flag_req <= 7'h01;
      wb(1'b1, `ADCRAT_OFF_SFIO, 8'h20);
      no_conv();
      wb(1'b1, `ADCRAT_OFF_SFIO, 8'h40);
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'hA0);
      no_conv();
      new_sample(0);
      wb(1'b1, `ADCRAT_OFF_SFIO, 8'h20);
      finish_conv(2'b11, 8'h00, c_norm);
      check_res();
      wb(1'b1, `ADCRAT_OFF_SFIO, 8'h00);
      no_conv();
      flag_req <= 7'h00;
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'hB0);
      for (int k = 1; k < 8; k++) begin
         wb(1'b1, `ADCRAT_OFF_SFIO, 8'(k << 5));
         new_sample(0);
         flag_req <= 7'(1 << (k - 1));
         finish_conv(2'b11, 8'hB0, c_norm);
         flag_req <= 7'h00;
         check_res();
      end
      wb(1'b1, `ADCRAT_OFF_SFIO, 8'h00);
      new_sample(0);
      exp_q.push_back(s);
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'hE7);
      finish_conv(2'b01, 8'hB7, c_norm);
      check_res();
      finish_conv(2'b01, 8'hB7, c_norm);
      check_res();
      wb(1'b1, `ADCRAT_OFF_CTRL, 8'h00);
      give_verdict();
   end
endmodule
